/* mrr_defs.svh */
// Constant definitions for the move, rotate and return execution unit.
`ifndef MRR_DEFS_SVH
`define MRR_DEFS_SVH

// ============================================================
// Register byte offsets on the AHB-Lite slave.
`define MRR_OFS_INSTR   8'h00
`define MRR_OFS_ACC     8'h04
`define MRR_OFS_STATUS  8'h08
`define MRR_OFS_PC      8'h0C
`define MRR_OFS_STACK   8'h10
`define MRR_OFS_FADDR   8'h14
`define MRR_OFS_FDATA   8'h18

// ============================================================
// Status register field positions.
`define MRR_ST_CARRY    0
`define MRR_ST_ZERO     2
`define MRR_ST_BUSY     3
`define MRR_ST_INT_EN   7

// Stack register field positions (top entry low, depth count high).
`define MRR_STK_SP_LSB  16
`define MRR_STK_SP_MSB  18

// ============================================================
// Instruction word encodings, as mask and match pairs.
`define MRR_MSK_FILE    14'h3F80
`define MRR_VAL_ACC_TO_FILE  14'h0080
`define MRR_MSK_FD           14'h3F00
`define MRR_VAL_FILE_TO_DEST 14'h0800
`define MRR_VAL_ROT_LEFT     14'h0D00
`define MRR_VAL_ROT_RIGHT    14'h0C00
`define MRR_MSK_RET_LIT      14'h3C00
`define MRR_VAL_RET_LIT      14'h3400
`define MRR_VAL_RET_INT      14'h0009
`define MRR_MSK_NOP     14'h3F9F
`define MRR_VAL_NOP     14'h0000

// ============================================================
// Reset values.
`define MRR_RST_PC      13'h0000
`define MRR_RST_ACC     8'h00

`endif

/* mrr_pkg.sv */
// Types shared by the move, rotate and return execution unit.
`default_nettype none
package mrr_pkg;

    // ============================================================
    // Decoded instruction class.
    typedef enum logic [2:0] {
        OP_NOP    = 3'b000,  // No operation or unsupported word.
        OP_ACC_TO_FILE  = 3'b001,  // Copy accumulator into a file register.
        OP_FILE_TO_DEST = 3'b010,  // Move a file register to a destination.
        OP_ROT_LEFT     = 3'b011,  // Rotate left through carry.
        OP_ROT_RIGHT    = 3'b100,  // Rotate right through carry.
        OP_RET_LIT      = 3'b101,  // Return with a literal in the accumulator.
        OP_RET_INT      = 3'b110   // Return from interrupt.
    } mrr_op_t;

    // ============================================================
    // Complete state of the execution unit.
    typedef struct packed {
        logic [127:0][7:0] file;     // File registers.
        logic [7:0][12:0]  stack;    // Return stack entries.
        logic [2:0]        sp;       // Number of entries pushed, modulo depth.
        logic [12:0]       pc;       // Program counter.
        logic [7:0]        acc;      // Accumulator.
        logic              zero;     // Zero flag.
        logic              carry;    // Carry flag.
        logic              int_en;   // Global interrupt enable.
        logic              flush;    // Second cycle of a two-cycle return.
        logic [6:0]        faddr;    // File address for software access.
        logic [13:0]       last_ir;  // Last instruction word executed.
        logic              dp_sel;   // A data phase is pending.
        logic              dp_wr;    // The pending data phase is a write.
        logic [7:0]        dp_addr;  // Byte offset of the pending data phase.
        logic [31:0]       rdata;    // Read data for the bus.
    } mrr_state_t;

endpackage
`default_nettype wire

/* mrr_exec.sv */
// Move, rotate and return execution unit with an AHB-Lite register slave.
`timescale 1ns/1ps
`default_nettype none
`include "mrr_defs.svh"

// Summary of operation
// RL1 - Accumulator copied to file; flags untouched.
// RL2 - Move file to accumulator or back.
// RL3 - Move file sets zero from moved value.
// RL4 - Rotate left through carry; only carry changes.
// RL5 - Rotate right through carry; only carry changes.
// RL6 - Return literal loads accumulator; flags untouched.
// RL7 - Return literal pops stack into counter.
// RL8 - Return literal takes two instruction cycles.
// RL9 - Interrupt return pops counter, sets enable.
// RL10 - No operation only advances the counter.
module mrr_exec
    import mrr_pkg::*;
(
    input  wire logic        hclk,      // Clock, one instruction cycle each rising edge.
    input  wire logic        hresetn,   // Asynchronous reset, active low.
    input  wire logic        hsel,      // Slave select.
    input  wire logic [31:0] haddr,     // Byte address.
    input  wire logic [1:0]  htrans,    // Transfer type.
    input  wire logic        hwrite,    // Write when high.
    input  wire logic [2:0]  hsize,     // Transfer size, word only.
    input  wire logic [31:0] hwdata,    // Write data.
    input  wire logic        hready,    // Bus ready.
    output logic      [31:0] hrdata,    // Read data.
    output logic             hreadyout, // Slave ready.
    output logic             hresp      // Response, always OKAY.
);

    // ============================================================
    // State and decode signals.
    mrr_state_t  q;        // Registered state.
    mrr_state_t  d;        // Next state.
    logic [13:0] ir;       // Instruction word from the bus.
    mrr_op_t     op;       // Decoded class of the word.
    logic [6:0]  fidx;     // File address operand.
    logic [7:0]  fval;     // Addressed file register contents.
    logic        dbit;     // Destination select: 1 is the file register.
    logic [7:0]  rot_l;    // Left rotation result.
    logic [7:0]  rot_r;    // Right rotation result.
    logic [2:0]  sp_m1;    // Stack count after a pop.
    logic [12:0] top;      // Entry on top of the return stack.
    logic        instr_wr; // A write to the instruction register is in data phase.
    logic        ex_go;    // The instruction executes in this cycle.
    logic        ap_take;  // An address phase is taken in this cycle.

    assign ir    = hwdata[13:0];
    assign fidx  = ir[6:0];
    assign fval  = q.file[fidx];
    assign dbit  = ir[7];
    assign rot_l = {fval[6:0], q.carry};
    assign rot_r = {q.carry, fval[7:1]};
    assign sp_m1 = q.sp - 3'h1;
    assign top   = q.stack[sp_m1];

    // Classifies the instruction word; anything not recognised acts as no operation.
    always_comb begin
        if ((ir & `MRR_MSK_FILE) == `MRR_VAL_ACC_TO_FILE) begin
            op = OP_ACC_TO_FILE;
        end else if ((ir & `MRR_MSK_FD) == `MRR_VAL_FILE_TO_DEST) begin
            op = OP_FILE_TO_DEST;
        end else if ((ir & `MRR_MSK_FD) == `MRR_VAL_ROT_LEFT) begin
            op = OP_ROT_LEFT;
        end else if ((ir & `MRR_MSK_FD) == `MRR_VAL_ROT_RIGHT) begin
            op = OP_ROT_RIGHT;
        end else if ((ir & `MRR_MSK_RET_LIT) == `MRR_VAL_RET_LIT) begin
            op = OP_RET_LIT;
        end else if (ir == `MRR_VAL_RET_INT) begin
            op = OP_RET_INT;
        end else begin
            op = OP_NOP;
        end
    end

    // ============================================================
    // Bus handshake.
    // A new instruction waits out the discard cycle of a return.
    assign instr_wr  = q.dp_sel && q.dp_wr && (q.dp_addr == `MRR_OFS_INSTR);
    assign hreadyout = !(instr_wr && q.flush); // see RL8
    assign ex_go     = instr_wr && !q.flush;
    assign ap_take   = hsel && htrans[1] && hready;
    assign hresp     = 1'b0;
    assign hrdata    = q.rdata;

    // ============================================================
    // Next-state logic: register writes, execution and read data.
    always_comb begin
        d       = q;
        d.flush = 1'b0;
        // Data phase of a write: apply it to the addressed register.
        if (q.dp_sel && q.dp_wr) begin
            case (q.dp_addr)
                `MRR_OFS_INSTR: begin
                    if (q.flush) begin
                        d.dp_sel = 1'b1; // Hold the data phase while stalled.
                    end
                end
                `MRR_OFS_ACC: begin
                    d.acc = hwdata[7:0];
                end
                `MRR_OFS_STATUS: begin
                    d.carry  = hwdata[`MRR_ST_CARRY];
                    d.zero   = hwdata[`MRR_ST_ZERO];
                    d.int_en = hwdata[`MRR_ST_INT_EN];
                end
                `MRR_OFS_PC: begin
                    d.pc = hwdata[12:0];
                end
                `MRR_OFS_STACK: begin
                    // A write pushes a return address, as a call would.
                    d.stack[q.sp] = hwdata[12:0];
                    d.sp          = q.sp + 3'h1;
                end
                `MRR_OFS_FADDR: begin
                    d.faddr = hwdata[6:0];
                end
                `MRR_OFS_FDATA: begin
                    d.file[q.faddr] = hwdata[7:0];
                end
                default: begin
                    // Unmapped writes are ignored.
                end
            endcase
        end
        // Execute the instruction written this cycle.
        if (ex_go) begin
            d.last_ir = ir;
            d.pc      = q.pc + 13'h1;
            case (op)
                OP_ACC_TO_FILE: begin
                    d.file[fidx] = q.acc; // see RL1
                end
                OP_FILE_TO_DEST: begin
                    if (dbit) begin
                        d.file[fidx] = fval; // see RL2
                    end else begin
                        d.acc = fval; // see RL2
                    end
                    d.zero = (fval == 8'h00); // see RL3
                end
                OP_ROT_LEFT: begin
                    if (dbit) begin
                        d.file[fidx] = rot_l; // see RL4
                    end else begin
                        d.acc = rot_l; // see RL4
                    end
                    d.carry = fval[7]; // see RL4
                end
                OP_ROT_RIGHT: begin
                    if (dbit) begin
                        d.file[fidx] = rot_r; // see RL5
                    end else begin
                        d.acc = rot_r; // see RL5
                    end
                    d.carry = fval[0]; // see RL5
                end
                OP_RET_LIT: begin
                    d.acc   = ir[7:0]; // see RL6
                    d.pc    = top;     // see RL7
                    d.sp    = sp_m1;   // see RL7
                    d.flush = 1'b1;    // see RL8
                end
                OP_RET_INT: begin
                    d.pc     = top;   // see RL9
                    d.sp     = sp_m1; // see RL9
                    d.int_en = 1'b1;  // see RL9
                    d.flush = 1'b1;
                end
                default: begin
                    // No operation: only the counter advances. see RL10
                end
            endcase
        end
        // Address phase: latch the transfer and prepare read data.
        if (ap_take) begin
            d.dp_sel  = 1'b1;
            d.dp_wr   = hwrite;
            d.dp_addr = haddr[7:0];
            if (!hwrite) begin
                case (haddr[7:0])
                    `MRR_OFS_INSTR:  d.rdata = {18'h00000, q.last_ir};
                    `MRR_OFS_ACC:    d.rdata = {24'h000000, q.acc};
                    // Busy shows the discard cycle under way at the address phase.
                    `MRR_OFS_STATUS: d.rdata = {24'h000000, q.int_en, 3'h0, q.flush,
                                                q.zero, 1'b0, q.carry};
                    `MRR_OFS_PC:     d.rdata = {19'h00000, q.pc};
                    `MRR_OFS_STACK:  d.rdata = {13'h0000, q.sp, 3'h0, top};
                    `MRR_OFS_FADDR:  d.rdata = {25'h0000000, q.faddr};
                    `MRR_OFS_FDATA:  d.rdata = {24'h000000, q.file[q.faddr]};
                    default:         d.rdata = 32'h00000000;
                endcase
            end
        end else if (!(instr_wr && q.flush)) begin
            d.dp_sel = 1'b0;
        end
    end

    // Registers the whole state; reset clears every field.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q     <= '0;
            q.pc  <= `MRR_RST_PC;
            q.acc <= `MRR_RST_ACC;
        end else begin
            q <= d;
        end
    end

    // ============================================================
    // Checks on execution.
    a_acc_to_file: assert property (@(posedge hclk) disable iff (!hresetn) // see RL1
        ex_go && op == OP_ACC_TO_FILE |=> q.file[$past(fidx)] == $past(q.acc)
            && $stable(q.zero) && $stable(q.carry))
        else $error("Accumulator store to file failed.");

    a_move_dest: assert property (@(posedge hclk) disable iff (!hresetn) // see RL2
        ex_go && op == OP_FILE_TO_DEST |=> ($past(dbit) ? q.file[$past(fidx)] : q.acc)
            == $past(fval) && $stable(q.carry))
        else $error("Moved value not at its destination.");

    a_move_zero: assert property (@(posedge hclk) disable iff (!hresetn) // see RL3
        ex_go && op == OP_FILE_TO_DEST |=> q.zero == ($past(fval) == 8'h00))
        else $error("Zero flag wrong after move.");

    a_rot_left: assert property (@(posedge hclk) disable iff (!hresetn) // see RL4
        ex_go && op == OP_ROT_LEFT |=> ($past(dbit) ? q.file[$past(fidx)] : q.acc)
            == {$past(fval[6:0]), $past(q.carry)} && q.carry == $past(fval[7])
            && $stable(q.zero))
        else $error("Left rotation through carry wrong.");

    a_rot_right: assert property (@(posedge hclk) disable iff (!hresetn) // see RL5
        ex_go && op == OP_ROT_RIGHT |=> ($past(dbit) ? q.file[$past(fidx)] : q.acc)
            == {$past(q.carry), $past(fval[7:1])} && q.carry == $past(fval[0])
            && $stable(q.zero))
        else $error("Right rotation through carry wrong.");

    a_lit_acc: assert property (@(posedge hclk) disable iff (!hresetn) // see RL6
        ex_go && op == OP_RET_LIT |=> q.acc == $past(ir[7:0])
            && $stable(q.zero) && $stable(q.carry))
        else $error("Literal not loaded on return.");

    a_lit_pop: assert property (@(posedge hclk) disable iff (!hresetn) // see RL7
        ex_go && op == OP_RET_LIT |=> q.pc == $past(top) && q.sp == $past(sp_m1))
        else $error("Return did not pop the stack.");

    a_lit_two_cycles: assert property (@(posedge hclk) disable iff (!hresetn) // see RL8
        ex_go && op == OP_RET_LIT |=> q.flush && !ex_go ##1 !q.flush)
        else $error("Return did not take two cycles.");

    a_int_return: assert property (@(posedge hclk) disable iff (!hresetn) // see RL9
        ex_go && op == OP_RET_INT |=> q.int_en && q.pc == $past(top)
            && q.sp == $past(sp_m1)
            && $stable(q.zero) && $stable(q.carry))
        else $error("Interrupt return wrong.");

    a_nop_still: assert property (@(posedge hclk) disable iff (!hresetn) // see RL10
        ex_go && op == OP_NOP |=> q.pc == $past(q.pc) + 13'h1 && $stable(q.acc)
            && $stable(q.file) && $stable(q.sp) && !q.flush)
        else $error("No operation changed state.");

endmodule
`default_nettype wire

/* mrr_exec_tb.sv */
// Self-checking testbench for the move, rotate and return execution unit.
`timescale 1ns/1ps
`default_nettype none
`include "mrr_defs.svh"

module testbench;

    // ============================================================
    // Bus signals and design instance.
    logic        hclk;      // Bench clock, 50 MHz.
    logic        hresetn;   // Reset, active low.
    logic        hsel;      // Slave select.
    logic [31:0] haddr;     // Byte address.
    logic [1:0]  htrans;    // Transfer type.
    logic        hwrite;    // Write when high.
    logic [2:0]  hsize;     // Word transfers only.
    logic [31:0] hwdata;    // Write data.
    logic        hready;    // Bus ready, taken from the one slave.
    logic [31:0] hrdata;    // Read data.
    logic        hreadyout; // Slave ready.
    logic        hresp;     // Slave response.
    logic [31:0] rdat;      // Data taken by the last transfer.
    int          errors;    // Mismatches seen.
    int          n_checks;  // Comparisons made.

    // Reference model of the unit's programmer-visible state.
    logic [7:0]  m_file [128]; // File registers.
    logic [12:0] m_stk [8];    // Return stack entries.
    logic [7:0]  m_acc;        // Accumulator.
    logic [12:0] m_pc;         // Program counter.
    logic [2:0]  m_sp;         // Stack depth count, wraps at eight.
    logic        m_c;          // Carry flag.
    logic        m_z;          // Zero flag.
    logic        m_ie;         // Global interrupt enable.

    assign hready = hreadyout;

    mrr_exec i_mrr_exec (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hrdata    (hrdata),
        .hreadyout (hreadyout),
        .hresp     (hresp)
    );

    // The clock toggles every half period of 10 ns.
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    // ============================================================
    // Checking and reporting.
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Compares one value and reports a difference at once.
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Waits for a rising edge with ready high; a stuck slave ends the run.
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            errors++;
            $display("mismatch hreadyout expected 1 seen %b", hreadyout);
            results();
        end
    endtask

    // One single word transfer: address phase, then data phase.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h000000, a};
        hwrite <= w;
        wait_ready();
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= wd;
        wait_ready();
        rdat = hrdata;
    endtask

    // Expected status word; busy is only set in a return's discard cycle.
    function automatic logic [31:0] st(input logic busy);
        return {24'h000000, m_ie, 3'h0, busy, m_z, 1'b0, m_c};
    endfunction

    // Rotation through carry: new carry on top, result below.
    function automatic logic [8:0] rot(input logic [7:0] v, input logic c, input logic left);
        return left ? {v[7], v[6:0], c} : {v[0], c, v[7:1]};
    endfunction

    // ============================================================
    // Main sequence.
    initial begin
        logic [6:0]  f;
        logic        d;
        logic [7:0]  k;
        logic [7:0]  v;
        logic [8:0]  r;
        logic [13:0] w;
        logic [12:0] ret;
        int          op;
        hresetn = 1'b0;
        hsel = 1'b0;
        htrans = 2'b00;
        haddr = 32'h00000000;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        errors = 0;
        n_checks = 0;
        {m_acc, m_pc, m_sp, m_c, m_z, m_ie} = '0;
        foreach (m_file[i]) m_file[i] = 8'h00;
        foreach (m_stk[i]) m_stk[i] = 13'h0000;
        void'($urandom(32'h004D7FF0));
        repeat (3) @(posedge hclk);
        chk("hreadyout in reset", {31'h0, hreadyout}, 32'h1);
        chk("hresp in reset", {31'h0, hresp}, 32'h0);
        hresetn <= 1'b1;
        // Every register, and the unmapped word above them, reads zero.
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, 8'(i * 4), 32'h0);
            chk("reset read", rdat, 32'h0);
        end
        $display("test reset_values done");
        // Random operands; the first seven passes take every instruction once.
        for (int it = 0; it < 200; it++) begin
            f = 7'($urandom);
            d = 1'($urandom);
            k = (it == 4) ? 8'hFF : 8'($urandom);
            v = ($urandom % 4 == 0) ? 8'h00 : 8'($urandom);
            op = (it < 7) ? it : int'($urandom % 7);
            {m_acc, m_c, m_z, m_ie} = 11'($urandom);
            m_pc = (it == 6) ? 13'h1FFF : 13'($urandom);
            ret = 13'($urandom);
            bus(1'b1, `MRR_OFS_ACC, {24'h0, m_acc});
            bus(1'b1, `MRR_OFS_STATUS, st(1'b0));
            bus(1'b1, `MRR_OFS_PC, {19'h0, m_pc});
            bus(1'b1, `MRR_OFS_FADDR, {25'h0, f});
            bus(1'b1, `MRR_OFS_FDATA, {24'h0, v});
            bus(1'b1, `MRR_OFS_STACK, {19'h0, ret});
            m_file[f] = v;
            m_stk[m_sp] = ret;
            m_sp++;
            r = rot(v, m_c, op == 2);
            case (op)
                0: begin
                    w = `MRR_VAL_ACC_TO_FILE | f;
                    m_file[f] = m_acc;
                end
                1: begin
                    w = `MRR_VAL_FILE_TO_DEST | {d, f};
                    m_z = (v == 8'h00);
                    if (d) m_file[f] = v; else m_acc = v;
                end
                2, 3: begin
                    w = ((op == 2) ? `MRR_VAL_ROT_LEFT : `MRR_VAL_ROT_RIGHT) | {d, f};
                    m_c = r[8];
                    if (d) m_file[f] = r[7:0]; else m_acc = r[7:0];
                end
                4: begin
                    w = `MRR_VAL_RET_LIT | k;
                    m_acc = k;
                end
                5: begin
                    w = `MRR_VAL_RET_INT;
                    m_ie = 1'b1;
                end
                default: w = `MRR_VAL_NOP;
            endcase
            // Returns pop the stack into the counter; all else steps it.
            if (op == 4 || op == 5) begin
                m_sp--;
                m_pc = m_stk[m_sp];
            end else begin
                m_pc++;
            end
            bus(1'b1, `MRR_OFS_INSTR, {18'h0, w});
            bus(1'b0, `MRR_OFS_STATUS, 32'h0);
            chk("status", rdat, st(op == 4 || op == 5));
            bus(1'b0, `MRR_OFS_ACC, 32'h0);
            chk("accumulator", rdat, {24'h0, m_acc});
            bus(1'b0, `MRR_OFS_PC, 32'h0);
            chk("program counter", rdat, {19'h0, m_pc});
            bus(1'b0, `MRR_OFS_FDATA, 32'h0);
            chk("file register", rdat, {24'h0, m_file[f]});
            bus(1'b0, `MRR_OFS_STACK, 32'h0);
            chk("stack", rdat, {13'h0, m_sp, 3'h0, m_stk[m_sp - 3'd1]});
            bus(1'b0, `MRR_OFS_INSTR, 32'h0);
            chk("last word", rdat, {18'h0, w});
        end
        $display("test random_ops done");
        results();
    end

endmodule

`default_nettype wire
